// ### design/xacs_decode.sv
`include "xacs_regs.svh"
`default_nettype none
// Pure combinational decode of extended address and emulation select
module xacs_decode
  import xacs_pkg::*;
(
  input wire xacs_req_s req,
  input wire xacs_alloc_e alloc,
  input wire logic [1:0] pag_sw,
  input wire logic upper_map,
  output var xacs_dec_s dec
);
  logic [1:0] quad; // Address quadrant
  logic [5:0] base; // Lowest on-chip page
  logic win_int; // Window access is internal

  // Internal/external page classification
  always_comb begin
    unique case (pag_sw)
      2'h0: base = `XACS_PG_SW0;
      2'h1: base = `XACS_PG_SW1;
      2'h2: base = `XACS_PG_SW2;
      default: base = `XACS_PG_SW3; // All pages on chip
    endcase
    win_int = (req.page >= base);
  end

  // Address and select per quadrant and allocation
  always_comb begin
    quad = req.addr[15:14];
    dec.xaddr = `XACS_XA_TOP;
    dec.ecs_n = 1'b1;
    unique case (quad)
      `XACS_QD_LOW: begin
        dec.xaddr = `XACS_XA_LOW;
        // Only the full allocation reaches the lowest block
        dec.ecs_n = (alloc == XACS_ALLOC_64K) ? upper_map : 1'b1;
      end
      `XACS_QD_MID: begin
        dec.xaddr = `XACS_XA_MID;
        dec.ecs_n = (alloc == XACS_ALLOC_48K || alloc == XACS_ALLOC_64K)
          ? upper_map : 1'b1;
      end
      `XACS_QD_WIN: begin
        dec.xaddr = req.page;
        unique case (alloc)
          XACS_ALLOC_0K: dec.ecs_n = 1'b0;
          XACS_ALLOC_16K: dec.ecs_n = 1'b1;
          default: dec.ecs_n = ~win_int;
        endcase
      end
      default: begin
        dec.xaddr = `XACS_XA_TOP;
        dec.ecs_n = 1'b0;
      end
    endcase
  end
endmodule : xacs_decode
`default_nettype wire

// ### design/xacs_top.sv
// Operation
// - Window access drives page index out
// - Outside window drive fixed upper address
// - Address outputs only with emulation control, expanded; selects driven with control alone
// - 0K: select low for window, top
// - 16K: select low only top block
// - 48K: mid by map bit, window internal
// - 64K: low half by map bit
// - Select active low, chosen by allocation
// - Bit7 emulation select, bit6 external select
// - Paging switches set internal page range
`include "xacs_regs.svh"
`default_nettype none
module xacs_top
  import xacs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [15:0] CPU_ADDR,
  input wire logic BUS_VALID,
  input wire logic EXT_ACCESS,
  input wire logic [5:0] PROGRAM_PAGE_INDEX,
  input wire xacs_alloc_e ALLOC_SIZE,
  input wire logic [1:0] PAGING_CONFIG_SWITCHES,
  input wire logic UPPER_MEMORY_MAP_SELECT,
  input wire logic EMULATION_PORT_CONTROL,
  input wire logic EXPANDED_MODE,
  input wire logic [7:0] GPIO_OUT,
  input wire logic [7:0] GPIO_OE,
  output logic [7:0] PORT_OUT,
  output logic [7:0] PORT_OE
);
  xacs_req_s req; // Current bus cycle
  xacs_dec_s dec; // Decode result
  logic [7:0] port_d, port_q; // Port drive value
  logic [7:0] oe_d, oe_q; // Port enables
  logic show; // Extended function visible
  logic xcs_n; // External select, active low

  assign req = '{addr: CPU_ADDR, page: PROGRAM_PAGE_INDEX, ext_sel: EXT_ACCESS};

  // Size comes in as a strap-like static input
  xacs_decode u_dec (
    .req(req),
    .alloc(ALLOC_SIZE),
    .pag_sw(PAGING_CONFIG_SWITCHES),
    .upper_map(UPPER_MEMORY_MAP_SELECT),
    .dec(dec)
  );

  // Port content, registered so outputs come from flops
  always_comb begin
    show = EMULATION_PORT_CONTROL & EXPANDED_MODE;
    // External select only when emulation select idle
    xcs_n = ~(BUS_VALID & req.ext_sel & dec.ecs_n);
    port_d = GPIO_OUT;
    oe_d = GPIO_OE;
    if (EMULATION_PORT_CONTROL) begin
      // Bits 7 and 6 leave general I/O use
      port_d[`XACS_BIT_ECS] = show ? (dec.ecs_n | ~BUS_VALID) : 1'b1;
      port_d[`XACS_BIT_XCS] = show ? xcs_n : 1'b1;
      oe_d[`XACS_BIT_ECS] = 1'b1;
      oe_d[`XACS_BIT_XCS] = 1'b1;
      if (show) begin
        port_d[5:0] = dec.xaddr;
        oe_d[5:0] = 6'h3f;
      end
    end
  end

  // Register stage, frozen while clock enable low
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      port_q <= `XACS_RST_PORT;
      oe_q <= `XACS_RST_OE;
    end else if (CLK_EN) begin
      port_q <= port_d;
      oe_q <= oe_d;
    end
  end

  assign PORT_OUT = port_q;
  assign PORT_OE = oe_q;

  // Checks on the registered port; each looks one clock edge after the
  // inputs that it judges, since the port lags the decode by one flop

  // Top block always selects emulation memory with a fixed address
  a_top_block: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && BUS_VALID && show && CPU_ADDR[15:14] == 2'h3
    |=> PORT_OUT[7] == 1'b0 && PORT_OUT[5:0] == 6'h3f)
    else $error("top block select wrong");

  // Window carries the page index, bus valid or not
  a_window_page: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && CPU_ADDR[15:14] == 2'h2
    |=> PORT_OUT[5:0] == $past(PROGRAM_PAGE_INDEX))
    else $error("window page not driven");

  // Lowest block carries its fixed upper address
  a_low_addr: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && CPU_ADDR[15:14] == 2'h0 |=> PORT_OUT[5:0] == 6'h3d)
    else $error("low fixed address wrong");

  // Second block carries its fixed upper address
  a_mid_fixed: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && CPU_ADDR[15:14] == 2'h1 |=> PORT_OUT[5:0] == 6'h3e)
    else $error("mid fixed address wrong");

  // Control clear hands the whole port back to general I/O
  a_hidden_gpio: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !EMULATION_PORT_CONTROL |=> PORT_OUT == $past(GPIO_OUT))
    else $error("gpio not passed");

  // Same for the enables, so no stale drive remains on the pins
  a_gpio_oe: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !EMULATION_PORT_CONTROL |=> PORT_OE == $past(GPIO_OE))
    else $error("gpio enables not passed");

  // Control set outside expanded modes: selects parked, address hidden
  a_hidden_addr: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && EMULATION_PORT_CONTROL && !EXPANDED_MODE
    |=> PORT_OUT[5:0] == $past(GPIO_OUT[5:0]) && PORT_OUT[7:6] == 2'b11)
    else $error("address shown outside expanded mode");

  // 0K: select follows address bit 15 only
  a_zero_alloc: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_0K
    |=> PORT_OUT[7] == ($past(CPU_ADDR[15]) ? 1'b0 : 1'b1))
    else $error("0K select wrong");

  // 16K: everything below the top block stays deselected
  a_win_16k: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_16K
    && CPU_ADDR[15:14] != 2'h3 |=> PORT_OUT[7] == 1'b1)
    else $error("16K select wrong");

  // 48K: lowest block never selects
  a_low_48k: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_48K
    && CPU_ADDR[15:14] == 2'h0 |=> PORT_OUT[7] == 1'b1)
    else $error("48K low select wrong");

  // 48K: second block follows the map bit
  a_mid_48k: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_48K && CPU_ADDR[15:14] == 2'h1
    |=> PORT_OUT[7] == $past(UPPER_MEMORY_MAP_SELECT))
    else $error("48K mid select wrong");

  // 48K with every page on chip: window always selects
  a_win_48k: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_48K
    && CPU_ADDR[15:14] == 2'h2 && PAGING_CONFIG_SWITCHES == 2'h3 |=> PORT_OUT[7] == 1'b0)
    else $error("48K window select wrong");

  // 64K: lower half follows the map bit
  a_low_64k: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_64K && !CPU_ADDR[15]
    |=> PORT_OUT[7] == $past(UPPER_MEMORY_MAP_SELECT))
    else $error("64K low select wrong");

  // Smallest on-chip range: only the top eight pages are internal
  a_win_internal: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_64K && CPU_ADDR[15:14] == 2'h2
    && PAGING_CONFIG_SWITCHES == 2'h0
    |=> PORT_OUT[7] == ($past(PROGRAM_PAGE_INDEX) < 6'h38))
    else $error("window internal wrong");

  // Second switch setting: top sixteen pages internal
  a_win_sw1: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_64K && CPU_ADDR[15:14] == 2'h2
    && PAGING_CONFIG_SWITCHES == 2'h1
    |=> PORT_OUT[7] == ($past(PROGRAM_PAGE_INDEX) < 6'h30))
    else $error("window internal wrong, second setting");

  // Third switch setting: upper half of the pages internal
  a_win_sw2: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && ALLOC_SIZE == XACS_ALLOC_64K && CPU_ADDR[15:14] == 2'h2
    && PAGING_CONFIG_SWITCHES == 2'h2
    |=> PORT_OUT[7] == ($past(PROGRAM_PAGE_INDEX) < 6'h20))
    else $error("window internal wrong, third setting");

  // Free bus cycles never strobe either select
  a_idle_select: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && !BUS_VALID |=> PORT_OUT[7:6] == 2'b11)
    else $error("select active on idle bus");

  // External select when emulation memory is not addressed
  a_ext_select: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show && BUS_VALID && EXT_ACCESS && ALLOC_SIZE == XACS_ALLOC_0K
    && CPU_ADDR[15:14] == 2'h0 |=> PORT_OUT[7:6] == 2'b10)
    else $error("external select wrong");

  // Both select pins are driven whenever control is set
  a_select_oe: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && EMULATION_PORT_CONTROL |=> PORT_OE[7:6] == 2'b11)
    else $error("select pins not driven");

  // Address pins are driven while the function is visible
  a_addr_oe: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && show |=> PORT_OE[5:0] == 6'h3f)
    else $error("address pins not driven");

  // Judged after the edge, so a stale GPIO value cannot trip it
  a_selects_excl: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && EMULATION_PORT_CONTROL |=> !(PORT_OUT[7] == 1'b0 && PORT_OUT[6] == 1'b0))
    else $error("both selects active");

  // Clock enable low freezes the whole port
  a_hold_frozen: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !CLK_EN |=> $stable(PORT_OUT) && $stable(PORT_OE))
    else $error("port moved while frozen");

  // Reset leaves the port undriven
  a_reset_clear: assert property (@(posedge CORE_CLK)
    SYS_RST |=> PORT_OUT == `XACS_RST_PORT && PORT_OE == `XACS_RST_OE)
    else $error("port not cleared by reset");

  // Main scenarios
  c_window: cover property (@(posedge CORE_CLK) show && CPU_ADDR[15:14] == 2'h2);
  c_ecs_low: cover property (@(posedge CORE_CLK) show && PORT_OUT[7] == 1'b0);
  c_xcs_low: cover property (@(posedge CORE_CLK) show && PORT_OUT[6] == 1'b0);
  c_hidden: cover property (@(posedge CORE_CLK) EMULATION_PORT_CONTROL && !EXPANDED_MODE);
  c_frozen: cover property (@(posedge CORE_CLK) !CLK_EN && show);
endmodule : xacs_top
`default_nettype wire

// ### inc/xacs_pkg.sv
`default_nettype none
package xacs_pkg;
  // Allocated physical program memory size
  typedef enum logic [1:0] {
    XACS_ALLOC_0K,
    XACS_ALLOC_16K,
    XACS_ALLOC_48K,
    XACS_ALLOC_64K
  } xacs_alloc_e;
  // One bus cycle request
  typedef struct packed {
    logic [15:0] addr;
    logic [5:0] page;
    logic ext_sel;
  } xacs_req_s;
  // Decode result
  typedef struct packed {
    logic [5:0] xaddr;
    logic ecs_n;
  } xacs_dec_s;
endpackage : xacs_pkg
`default_nettype wire

// ### inc/xacs_regs.svh
`ifndef XACS_REGS_SVH
`define XACS_REGS_SVH
// Fixed extended address values outside the page window
`define XACS_XA_LOW 6'h3d
`define XACS_XA_MID 6'h3e
`define XACS_XA_TOP 6'h3f
// Address quadrant codes, taken from address bits 15:14
`define XACS_QD_LOW 2'h0
`define XACS_QD_MID 2'h1
`define XACS_QD_WIN 2'h2
`define XACS_QD_TOP 2'h3
// Lowest internal page per paging switch setting
`define XACS_PG_SW0 6'h38
`define XACS_PG_SW1 6'h30
`define XACS_PG_SW2 6'h20
`define XACS_PG_SW3 6'h00
// Port bit positions
`define XACS_BIT_ECS 7
`define XACS_BIT_XCS 6
// Reset values
`define XACS_RST_PORT 8'h00
`define XACS_RST_OE 8'h00
`endif

// ### verif/xacs_emu_mem.sv
`default_nettype none
// Emulator memory seen from the port pins
module xacs_emu_mem (
  input wire logic [7:0] pins,
  input wire logic [7:0] pins_oe,
  output logic sel,
  output logic [5:0] xaddr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Selected only while bit 7 is driven low; an undriven pin never selects
  assign sel = pins_oe[7] & ~pins[7];
  // Upper address lines as the memory sees them
  assign xaddr = pins[5:0];
endmodule : xacs_emu_mem
`default_nettype wire

// ### verif/xacs_top_tb.sv
`default_nettype none
// Compare two values and count the result
`define XACS_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module xacs_top_tb import xacs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, clk_en = 1, valid = 1, ext = 0, map = 0, epc = 1, expd = 1;
  logic [15:0] addr = 16'h0000;
  logic [5:0] page = 6'h00;
  xacs_alloc_e alloc = XACS_ALLOC_0K;
  logic [1:0] sw = 2'h0;
  logic [7:0] gout = 8'h5a, goe = 8'h0f, port_out, port_oe;
  logic sel;
  logic [5:0] xa;
  int n_mismatch = 0, compares = 0, cyc = 0;
  // 200 MHz core clock
  always #2.5 clk = ~clk;
  xacs_top DUT (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(clk_en), .CPU_ADDR(addr),
    .BUS_VALID(valid), .EXT_ACCESS(ext), .PROGRAM_PAGE_INDEX(page), .ALLOC_SIZE(alloc),
    .PAGING_CONFIG_SWITCHES(sw), .UPPER_MEMORY_MAP_SELECT(map),
    .EMULATION_PORT_CONTROL(epc), .EXPANDED_MODE(expd), .GPIO_OUT(gout), .GPIO_OE(goe),
    .PORT_OUT(port_out), .PORT_OE(port_oe));
  xacs_emu_mem EMU (.pins(port_out), .pins_oe(port_oe), .sel(sel), .xaddr(xa));
  // Expected select level from allocation, quadrant, switches and map bit
  function automatic logic exp_ecs(int a, int q, int s, int m, logic [5:0] pg);
    logic inw;
    inw = (s == 3) || (pg >= (s == 0 ? 6'h38 : s == 1 ? 6'h30 : 6'h20));
    case (a)
      0: return q < 2;
      1: return q != 3;
      2: return q == 0 ? 1'b1 : q == 1 ? m[0] : q == 2 ? !inw : 1'b0;
      default: return q < 2 ? m[0] : q == 2 ? !inw : 1'b0;
    endcase
  endfunction : exp_ecs
  // Closing report, reached once
  task print_verdict;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Every allocation, switch, map bit, quadrant and boundary page
  task automatic t_decode;
    logic [5:0] pg [6] = '{6'h1f, 6'h20, 6'h2f, 6'h30, 6'h37, 6'h38};
    for (int a = 0; a < 4; a++) begin
      for (int s = 0; s < 4; s++) begin
        for (int m = 0; m < 2; m++) begin
          for (int q = 0; q < 4; q++) begin
            for (int p = 0; p < 6; p++) begin
              alloc = xacs_alloc_e'(a);
              sw = 2'(s);
              map = m[0];
              addr = {q[1:0], 14'h1234};
              page = pg[p];
              @(negedge clk);
              `XACS_CHK(sel, !exp_ecs(a, q, s, m, pg[p]))
              `XACS_CHK(xa, q == 2 ? pg[p] : q == 3 ? 6'h3f : 6'h3d + 6'(q))
              `XACS_CHK(port_out[6], 1'b1)
              `XACS_CHK(port_oe, 8'hff)
            end
          end
        end
      end
    end
    $display("t_decode done");
  endtask : t_decode
  // External select, bus gating, clock enable hold and port hand-back
  task t_misc;
    alloc = XACS_ALLOC_0K;
    addr = 16'h1000;
    ext = 1;
    @(negedge clk);
    `XACS_CHK(port_out[7:6], 2'b10)
    valid = 0;
    @(negedge clk);
    `XACS_CHK(port_out[7:6], 2'b11)
    clk_en = 0;
    valid = 1;
    ext = 0;
    addr = 16'hc000;
    @(negedge clk);
    `XACS_CHK(port_out[7:6], 2'b11)
    clk_en = 1;
    expd = 0;
    @(negedge clk);
    `XACS_CHK(port_out, {2'b11, gout[5:0]})
    epc = 0;
    @(negedge clk);
    `XACS_CHK({port_out, port_oe}, {gout, goe})
    epc = 1;
    expd = 1;
    @(negedge clk);
    `XACS_CHK({port_out, port_oe}, 16'h7fff)
    $display("t_misc done");
  endtask : t_misc
  // Hang guard, well above the planned run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    `XACS_CHK({port_out, port_oe}, 16'h0000)
    rst = 0;
    t_decode();
    t_misc();
    print_verdict();
  end
endmodule : xacs_top_tb
`default_nettype wire
